// [fmdm_pkg.sv]
package fmdm_pkg;

  // ********************************************************************
  // Instruction and word layout
  // ********************************************************************
  localparam int          WORD_W     = 60;
  localparam int          COEF_W     = 48;
  localparam logic [5:0]  OP_RMUL    = 6'h21;
  localparam logic [5:0]  OP_DMUL    = 6'h22;
  localparam logic [5:0]  OP_MASK    = 6'h23;
  localparam logic [5:0]  OP_DIV     = 6'h24;

  // ********************************************************************
  // Exponent handling
  // ********************************************************************
  localparam logic signed [12:0] EXP_MAX       = 13'sh3FF;
  localparam logic signed [12:0] EXP_BIAS_POS  = 13'sh400;
  localparam logic signed [12:0] EXP_BIAS_NEG  = 13'sh3FF;
  localparam logic signed [12:0] MUL_EXP_CORR  = 13'sh030;
  localparam logic signed [12:0] DIV_EXP_CORR  = 13'sh030;

  // ********************************************************************
  // Rounding, special words and divider length
  // ********************************************************************
  localparam logic [95:0] RND_ONE    = 96'h0000_0000_0000_4000_0000_0000;
  localparam logic [11:0] INF_POS    = 12'h7FF;
  localparam logic [11:0] INF_NEG    = 12'h800;
  localparam logic [11:0] IND_POS    = 12'h3FF;
  localparam logic [11:0] IND_NEG    = 12'hC00;
  localparam logic [59:0] INF_WORD   = 60'h7FF_0000_0000_0000;
  localparam logic [59:0] INDEF_WORD = 60'h3FF_0000_0000_0000;
  localparam logic [59:0] ALL_ONES   = 60'hFFF_FFFF_FFFF_FFFF;
  localparam logic [5:0]  DIV_STEPS  = 6'h30;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_READ = 4'h2,
    S_EXEC = 4'h4,
    S_DIV  = 4'h8
  } unit_state_t;

endpackage

// [float_div_core.sv]
module float_div_core
  import fmdm_pkg::*;
#(
  parameter int STEPS_W = 6
)(
  input  logic        ref_clk,   // Processor clock.
  input  logic        reset,     // Synchronous reset, active high.
  input  logic        start,     // One-cycle start pulse.
  input  logic [47:0] rem_init,  // Upper half of the positioned dividend.
  input  logic [47:0] low_bits,  // Lower half, shifted in one bit per step.
  input  logic [47:0] divisor,   // Divisor coefficient magnitude.
  output logic        done,      // One-cycle pulse, quotient complete.
  output logic [47:0] quotient   // Assembled quotient bits.
);

  // ********************************************************************
  // Restoring trial subtraction, one quotient bit per cycle
  // ********************************************************************
  logic [47:0]        rem;
  logic [47:0]        next_rem;
  logic [47:0]        lowsh;
  logic [47:0]        next_lowsh;
  logic [47:0]        next_quotient;
  logic [STEPS_W-1:0] cnt;
  logic [STEPS_W-1:0] next_cnt;
  logic               next_done;
  logic [48:0]        cand;
  logic [49:0]        diff;
  logic               take;

  // The remainder is left in rem and never leaves the core.
  always_comb begin
    next_rem      = rem;
    next_lowsh    = lowsh;
    next_quotient = quotient;
    next_cnt      = cnt;
    next_done     = 1'b0;
    cand          = {rem, lowsh[47]};
    diff          = {1'b0, cand} - {2'b00, divisor};
    take          = ~diff[49];
    if (start) begin
      next_rem      = rem_init;
      next_lowsh    = low_bits;
      next_quotient = 48'h0;
      next_cnt      = STEPS_W'(DIV_STEPS);
    end else if (cnt != '0) begin
      next_rem      = take ? diff[47:0] : cand[47:0];
      next_lowsh    = {lowsh[46:0], 1'b0};
      next_quotient = {quotient[46:0], take};
      next_cnt      = cnt - 1'b1;
      next_done     = (cnt == STEPS_W'(1));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rem      <= 48'h0;
      lowsh    <= 48'h0;
      quotient <= 48'h0;
      cnt      <= '0;
      done     <= 1'b0;
    end else begin
      rem      <= next_rem;
      lowsh    <= next_lowsh;
      quotient <= next_quotient;
      cnt      <= next_cnt;
      done     <= next_done;
    end
  end

endmodule

// [float_mul_div_mask_unit.sv]
// Overview of operation
// - Rounded product: round bit 46, upper half.
// - Rounded product exponent: sum plus correction.
// - 95-bit normalized product: shift left, exponent minus one.
// - Unnormalized operands: upper half, no leading-one search.
// - Double product: no rounding, lower half.
// - Double product exponent 48 below upper form.
// - Double 95-bit normalized product: shift, decrement.
// - Double unnormalized: always lower 48 bits.
// - Double, zero exponents unnormalized: sign-extended 48-bit integer.
// - No overflow indication for integer products.
// - Mask: jk count of leading ones.
// - Mask reads no operand register.
// - Divide exponent: difference minus correction.
// - Trial-subtract until 48 quotient bits, then write.
// - Remainder discarded; unnormalized dividend still correct.
// - Dividend at least twice divisor: fault, indefinite.
// - Exponent range result wins over divide fault.
// - Infinite or indefinite operands raise exit conditions.
// - Status designator variant sets status bits instead.
module float_mul_div_mask_unit
  import fmdm_pkg::*;
(
  input  logic        ref_clk,            // Processor clock.
  input  logic        reset,              // Synchronous reset, active high.
  input  logic        psd_variant,        // Report conditions in the status designator.
  input  logic        issue_valid,        // Instruction offered by issue.
  input  logic [14:0] instr,              // Instruction word.
  output logic        ready,              // Unit idle, issue may be taken.
  output logic        rd_en,              // Operand read strobe.
  output logic [2:0]  rd_idx_a,           // First source index.
  output logic [2:0]  rd_idx_b,           // Second source index.
  input  logic [59:0] first_source_reg,   // First operand read data.
  input  logic [59:0] second_source_reg,  // Second operand read data.
  output logic        wr_en,              // Destination write strobe.
  output logic [2:0]  wr_idx,             // Destination index.
  output logic [59:0] dest_operand_reg,   // Destination write data.
  output logic        exit_infinite,      // Infinite operand exit condition.
  output logic        exit_indefinite,    // Indefinite operand exit condition.
  output logic        div_fault,          // Divide fault.
  output logic        psd_infinite,       // Infinite condition for status designator.
  output logic        psd_indefinite      // Indefinite condition for status designator.
);

  // ********************************************************************
  // Word helpers
  // ********************************************************************
  // Negative words are the one's complement of the whole word.
  function automatic logic [59:0] magn(input logic [59:0] w);
    magn = w[59] ? ~w : w;
  endfunction

  function automatic logic signed [12:0] exp_of(input logic [59:0] w);
    logic [59:0] m;
    m = magn(w);
    exp_of = $signed({2'b00, m[58:48]}) - (m[58] ? EXP_BIAS_POS : EXP_BIAS_NEG);
  endfunction

  function automatic logic out_of_range(input logic signed [12:0] e);
    out_of_range = (e > EXP_MAX) || (e < -EXP_MAX);
  endfunction

  // Overflow packs as infinite, underflow as zero, both signed.
  function automatic logic [59:0] pack(input logic s, input logic signed [12:0] e,
                                       input logic [47:0] c);
    logic [59:0] w;
    logic [12:0] f;
    f = 13'h0;
    if (e > EXP_MAX) begin
      w = INF_WORD;
    end else if (e < -EXP_MAX) begin
      w = 60'h0;
    end else begin
      f = e + ((e >= 0) ? EXP_BIAS_POS : EXP_BIAS_NEG);
      w = {1'b0, f[10:0], c};
    end
    pack = s ? ~w : w;
  endfunction

  function automatic logic is_inf(input logic [59:0] w);
    is_inf = (w[59:48] == INF_POS) || (w[59:48] == INF_NEG);
  endfunction

  function automatic logic is_ind(input logic [59:0] w);
    is_ind = (w[59:48] == IND_POS) || (w[59:48] == IND_NEG);
  endfunction

  // ********************************************************************
  // State
  // ********************************************************************
  unit_state_t state;
  unit_state_t next_state;
  logic [14:0] ins;
  logic [14:0] next_ins;
  logic [59:0] opa;
  logic [59:0] next_opa;
  logic [59:0] opb;
  logic [59:0] next_opb;
  logic        div_start;
  logic        next_div_start;
  logic        next_ready;
  logic        next_rd_en;
  logic [2:0]  next_rd_idx_a;
  logic [2:0]  next_rd_idx_b;
  logic        next_wr_en;
  logic [2:0]  next_wr_idx;
  logic [59:0] next_dest;
  logic        next_exit_inf;
  logic        next_exit_ind;
  logic        next_div_fault;
  logic        next_psd_inf;
  logic        next_psd_ind;
  logic        div_done;
  logic [47:0] quo;

  // ********************************************************************
  // Unpacked operands and arithmetic
  // ********************************************************************
  logic               [5:0]  op;
  logic               [5:0]  in_op;
  logic                      op_known;
  logic                      take;
  logic               [59:0] ma;
  logic               [59:0] mb;
  logic                      psign;
  logic signed        [12:0] ea;
  logic signed        [12:0] eb;
  logic               [47:0] ca;
  logic               [47:0] cb;
  logic                      both_norm;
  logic                      int_mode;
  logic               [95:0] prod;
  logic               [95:0] rprod;
  logic                      rshift;
  logic               [47:0] rcoef;
  logic signed        [12:0] rexp;
  logic                      dshift;
  logic               [47:0] dcoef;
  logic signed        [12:0] dexp;
  logic               [59:0] int_word;
  logic               [59:0] mask_word;
  logic                      div_ge;
  logic                      div_flt;
  logic signed        [12:0] qexp;
  logic                      div_oor;
  logic                      op_inf;
  logic                      op_ind;

  assign op       = ins[14:9];
  assign in_op    = instr[14:9];
  assign op_known = (in_op == OP_RMUL) || (in_op == OP_DMUL) || (in_op == OP_MASK) || (in_op == OP_DIV);
  assign take     = (state == S_IDLE) && issue_valid && op_known;

  assign ma        = magn(opa);
  assign mb        = magn(opb);
  assign psign     = opa[59] ^ opb[59];
  assign ea        = exp_of(opa);
  assign eb        = exp_of(opb);
  assign ca        = ma[47:0];
  assign cb        = mb[47:0];
  assign both_norm = ca[47] & cb[47];
  assign int_mode  = (ea == 13'sh000) && (eb == 13'sh000) && !ca[47] && !cb[47];

  // Multiply on magnitudes and reapply the sign; this matches a signed
  // one's-complement product without a second multiplier.
  assign prod   = {48'h0, ca} * {48'h0, cb};
  assign rprod  = prod + RND_ONE;
  // Only the one-place shift exists; unnormalized inputs get no search.
  assign rshift = both_norm & ~rprod[95];
  assign rcoef  = rshift ? rprod[94:47] : rprod[95:48];
  assign rexp   = ea + eb + MUL_EXP_CORR - {12'h0, rshift};
  assign dshift = both_norm & ~prod[95];
  assign dcoef  = dshift ? {prod[46:0], 1'b0} : prod[47:0];
  assign dexp   = ea + eb - {12'h0, dshift};
  assign int_word  = {{12{psign}}, dcoef ^ {48{psign}}};
  assign mask_word = ~(ALL_ONES >> ins[5:0]);

  // A dividend not below the divisor is pre-shifted one place so the
  // quotient still fits 48 bits; exponent absorbs the shift.
  assign div_ge  = (ca >= cb);
  assign div_flt = ({1'b0, ca} >= {cb, 1'b0});
  assign qexp    = ea - eb - DIV_EXP_CORR + {12'h0, div_ge};
  assign div_oor = out_of_range(qexp);

  assign op_inf = is_inf(opa) || is_inf(opb);
  assign op_ind = is_ind(opa) || is_ind(opb);

  float_div_core #(
    .STEPS_W (6)
  ) u_div (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .start    (div_start),
    .rem_init (div_ge ? {1'b0, ca[47:1]} : ca),
    .low_bits (div_ge ? {ca[0], 47'h0} : 48'h0),
    .divisor  (cb),
    .done     (div_done),
    .quotient (quo)
  );

  // ********************************************************************
  // Sequencing
  // ********************************************************************
  always_comb begin
    next_state     = state;
    next_ins       = ins;
    next_opa       = opa;
    next_opb       = opb;
    next_div_start = 1'b0;
    next_rd_en     = 1'b0;
    next_rd_idx_a  = rd_idx_a;
    next_rd_idx_b  = rd_idx_b;
    next_wr_en     = 1'b0;
    next_wr_idx    = wr_idx;
    next_dest      = dest_operand_reg;
    next_exit_inf  = 1'b0;
    next_exit_ind  = 1'b0;
    next_div_fault = 1'b0;
    next_psd_inf   = 1'b0;
    next_psd_ind   = 1'b0;
    case (state)
      S_IDLE: begin
        if (take) begin
          next_ins = instr;
          if (in_op == OP_MASK) begin
            next_state = S_EXEC;
          end else begin
            next_rd_en    = 1'b1;
            next_rd_idx_a = instr[5:3];
            next_rd_idx_b = instr[2:0];
            next_state    = S_READ;
          end
        end
      end
      S_READ: begin
        next_opa       = first_source_reg;
        next_opb       = second_source_reg;
        next_div_start = (op == OP_DIV);
        next_state     = (op == OP_DIV) ? S_DIV : S_EXEC;
      end
      S_EXEC: begin
        next_wr_en  = 1'b1;
        next_wr_idx = ins[8:6];
        next_state  = S_IDLE;
        case (op)
          OP_MASK: begin
            next_dest = mask_word;
          end
          OP_RMUL: begin
            next_dest = pack(psign, rexp, rcoef);
          end
          default: begin
            // Integer products never flag overflow.
            next_dest = int_mode ? int_word : pack(psign, dexp, dcoef);
          end
        endcase
        if (op != OP_MASK) begin
          next_exit_inf = !psd_variant && op_inf;
          next_exit_ind = !psd_variant && op_ind;
          next_psd_inf  = psd_variant && op_inf;
          next_psd_ind  = psd_variant && op_ind;
        end
      end
      S_DIV: begin
        if (div_done) begin
          next_wr_en     = 1'b1;
          next_wr_idx    = ins[8:6];
          next_state     = S_IDLE;
          next_div_fault = div_flt;
          if (div_flt && !div_oor) begin
            next_dest = INDEF_WORD;
          end else begin
            next_dest = pack(psign, qexp, quo);
          end
          next_exit_inf = !psd_variant && op_inf;
          next_exit_ind = !psd_variant && op_ind;
          next_psd_inf  = psd_variant && op_inf;
          next_psd_ind  = psd_variant && op_ind;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    next_ready = (next_state == S_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state            <= S_IDLE;
      ins              <= 15'h0;
      opa              <= 60'h0;
      opb              <= 60'h0;
      div_start        <= 1'b0;
      ready            <= 1'b1;
      rd_en            <= 1'b0;
      rd_idx_a         <= 3'h0;
      rd_idx_b         <= 3'h0;
      wr_en            <= 1'b0;
      wr_idx           <= 3'h0;
      dest_operand_reg <= 60'h0;
      exit_infinite    <= 1'b0;
      exit_indefinite  <= 1'b0;
      div_fault        <= 1'b0;
      psd_infinite     <= 1'b0;
      psd_indefinite   <= 1'b0;
    end else begin
      state            <= next_state;
      ins              <= next_ins;
      opa              <= next_opa;
      opb              <= next_opb;
      div_start        <= next_div_start;
      ready            <= next_ready;
      rd_en            <= next_rd_en;
      rd_idx_a         <= next_rd_idx_a;
      rd_idx_b         <= next_rd_idx_b;
      wr_en            <= next_wr_en;
      wr_idx           <= next_wr_idx;
      dest_operand_reg <= next_dest;
      exit_infinite    <= next_exit_inf;
      exit_indefinite  <= next_exit_ind;
      div_fault        <= next_div_fault;
      psd_infinite     <= next_psd_inf;
      psd_indefinite   <= next_psd_ind;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb_main @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  AST_DECODE: assert property (rd_en |-> rd_idx_a == $past(instr[5:3]) && rd_idx_b == $past(instr[2:0]))
    else $error("read indices do not follow the instruction");
  AST_MASK_NO_READ: assert property (take && in_op == OP_MASK |=> !rd_en ##1 (wr_en && !rd_en))
    else $error("mask read an operand register");
  AST_MASK_WORD: assert property (take && in_op == OP_MASK |-> ##2 wr_en && dest_operand_reg == ~(ALL_ONES >> $past(instr[5:0], 2)))
    else $error("mask word wrong");
  AST_MUL_WRITE: assert property (take && (in_op == OP_RMUL || in_op == OP_DMUL) |-> ##3 wr_en && wr_idx == $past(instr[8:6], 3))
    else $error("product not written on time");
  AST_DIV_LATENCY: assert property (take && in_op == OP_DIV |=> !wr_en [*8] ##43 !wr_en ##1 wr_en)
    else $error("quotient not written after 48 steps");
  AST_INT_SEXT: assert property (state == S_EXEC && op == OP_DMUL && int_mode |=> wr_en && dest_operand_reg[59:48] == {12{$past(psign)}})
    else $error("integer product not sign extended");
  AST_NO_OVF_FLAG: assert property (state == S_EXEC && op == OP_DMUL && int_mode && !op_inf && !op_ind |=> !exit_infinite && !psd_infinite && !div_fault)
    else $error("integer product raised a condition");
  AST_FAULT_INDEF: assert property (state == S_DIV && div_done && div_flt && !div_oor |=> div_fault && dest_operand_reg == INDEF_WORD)
    else $error("divide fault without indefinite result");
  AST_FAULT_RANGE: assert property (state == S_DIV && div_done && div_oor |=> wr_en && dest_operand_reg != INDEF_WORD)
    else $error("range result lost to divide fault");
  AST_EXIT_MODE: assert property ((exit_infinite || exit_indefinite) |-> wr_en && !$past(psd_variant))
    else $error("exit condition outside exit mode");
  AST_PSD_MODE: assert property ((psd_infinite || psd_indefinite) |-> wr_en && $past(psd_variant))
    else $error("status bit outside status variant");
  AST_RND_NORM: assert property (state == S_EXEC && op == OP_RMUL && both_norm && !out_of_range(rexp) |=> dest_operand_reg[47] != dest_operand_reg[59])
    else $error("rounded product of normalized operands not normalized");

  COV_MASK: cover property (take && in_op == OP_MASK);
  COV_DIV_FAULT: cover property (state == S_DIV && div_done && div_flt);
  COV_INT_MUL: cover property (state == S_EXEC && op == OP_DMUL && int_mode);
  COV_RND_SHIFT: cover property (state == S_EXEC && op == OP_RMUL && rshift);

endmodule

// [operand_file_model.sv]
module operand_file_model (
  input  logic        ref_clk,  // Processor clock.
  input  logic        rd_en,    // Read strobe.
  input  logic [2:0]  idx_a,    // First read index.
  input  logic [2:0]  idx_b,    // Second read index.
  input  logic        wr_en,    // Write strobe.
  input  logic [2:0]  wr_idx,   // Write index.
  input  logic [59:0] wr_data,  // Write data.
  output logic [59:0] data_a,   // First read data.
  output logic [59:0] data_b    // Second read data.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [59:0] regs [8];
  // Outside the read strobe the lines show the inverse, so a late sample is caught.
  assign data_a = rd_en ? regs[idx_a] : ~regs[idx_a];
  assign data_b = rd_en ? regs[idx_b] : ~regs[idx_b];
  always @(posedge ref_clk) if (wr_en) regs[wr_idx] <= wr_data;
endmodule

// [tb_top.sv]
module tb_top import fmdm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [59:0] d; logic [2:0] i; logic [4:0] f; logic chk;} note_t;
  logic ref_clk = 0, reset = 1, psd_variant = 0, issue_valid = 0, ready, rd_en, wr_en, sa, sb;
  logic exit_infinite, exit_indefinite, div_fault, psd_infinite, psd_indefinite;
  logic [14:0] instr = 0;
  logic [2:0]  rd_idx_a, rd_idx_b, wr_idx;
  logic [59:0] first_source_reg, second_source_reg, dest_operand_reg, a, b;
  logic [95:0] p;
  logic [47:0] ca, cb;
  int          fails = 0, check_count = 0, seed = 34, reads = 0, want_reads = 0, ea, eb;
  note_t       q[$], w;

  float_mul_div_mask_unit dut (.ref_clk, .reset, .psd_variant, .issue_valid, .instr, .ready, .rd_en, .rd_idx_a,
    .rd_idx_b, .first_source_reg, .second_source_reg, .wr_en, .wr_idx, .dest_operand_reg, .exit_infinite,
    .exit_indefinite, .div_fault, .psd_infinite, .psd_indefinite);
  operand_file_model rf (.ref_clk, .rd_en, .idx_a(rd_idx_a), .idx_b(rd_idx_b), .wr_en, .wr_idx,
    .wr_data(dest_operand_reg), .data_a(first_source_reg), .data_b(second_source_reg));

  initial forever #5 ref_clk = ~ref_clk;

  function automatic logic [59:0] fpack(input logic neg, input int e, input logic [47:0] c);
    logic [59:0] v;
    v = e > 1023 ? INF_WORD : {1'b0, 11'(e < 0 ? e + 1023 : e + 1024), c};
    return {60{neg}} ^ v;
  endfunction

  function automatic logic [47:0] rnd48();
    return 48'({$random(seed), $random(seed)});
  endfunction

  task automatic miss(input string s);
    fails++;
    $display("MISMATCH t=%0t %s", $time, s);
  endtask

  task automatic check_word(input note_t n);
    logic [4:0] f;
    f = {exit_infinite, exit_indefinite, div_fault, psd_infinite, psd_indefinite};
    check_count++;
    if ((n.chk && dest_operand_reg !== n.d) || wr_idx !== n.i || f !== n.f)
      miss($sformatf("got %h/%0d/%b want %h/%0d/%b", dest_operand_reg, wr_idx, f, n.d, n.i, n.f));
  endtask

  // Back-to-back issue: the next instruction is offered in the write cycle of the last.
  task automatic run(input logic [14:0] ins, input note_t n, input bit keep);
    while (ready !== 1'b1) @(negedge ref_clk);
    rf.regs[1] = a;
    rf.regs[2] = b;
    instr = ins;
    issue_valid = 1'b1;
    if (keep) q.push_back(n);
    if (keep && ins[14:9] != OP_MASK) want_reads++;
    @(negedge ref_clk);
    issue_valid = 1'b0;
  endtask

  always @(negedge ref_clk) begin
    if (rd_en === 1'b1) reads++;
    if (wr_en === 1'b1 && q.size() == 0) miss("write with nothing issued");
    else if (wr_en === 1'b1) check_word(q.pop_front());
  end

  task final_report;
    $display("Counts: %0d checks, %0d mismatches", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    for (int c = 0; c < 64; c++)
      run({OP_MASK, 3'h3, 6'(c)}, note_t'{c > 60 ? ALL_ONES : ALL_ONES << (60 - c), 3'h3, 5'h0, 1'b1}, 1);
    $display("mask test done");
    for (int n = 0; n < 20; n++) begin
      ca = rnd48() | 48'h8000_0000_0000;
      cb = rnd48() | 48'h8000_0000_0000;
      sa = 1'($random(seed));
      sb = 1'($random(seed));
      ea = $random(seed) % 200;
      eb = $random(seed) % 200;
      a = fpack(sa, ea, ca);
      b = fpack(sb, eb, cb);
      p = ca * cb + RND_ONE;
      w = note_t'{p[95] ? fpack(sa ^ sb, ea + eb + 48, p[95:48]) : fpack(sa ^ sb, ea + eb + 47, p[94:47]),
        3'(4 + n % 4), 5'h0, 1'b1};
      run({OP_RMUL, w.i, 6'o12}, w, 1);
      p = ca * cb;
      w.d = p[95] ? fpack(sa ^ sb, ea + eb, p[47:0]) : fpack(sa ^ sb, ea + eb - 1, {p[46:0], 1'b0});
      run({OP_DMUL, w.i, 6'o12}, w, 1);
      ca = rnd48() >> 18;
      cb = rnd48() >> 18;
      a = fpack(sa, 0, ca);
      b = fpack(sb, 0, cb);
      p = ca * cb;
      w.d = {60{sa ^ sb}} ^ {12'h0, p[47:0]};
      run({OP_DMUL, w.i, 6'o12}, w, 1);
    end
    $display("multiply test done");
    for (int n = 0; n < 8; n++) begin
      ca = rnd48() >> (n % 4);
      cb = rnd48() | 48'h8000_0000_0000;
      a = fpack(n[0], n * 30, ca);
      b = fpack(n[1], -n * 20, cb);
      p = ca >= cb ? (96'(ca) << 47) / cb : (96'(ca) << 48) / cb;
      w = note_t'{fpack(n[0] ^ n[1], n * 50 - (ca >= cb ? 47 : 48), p[47:0]), 3'h5, 5'h0, 1'b1};
      run({OP_DIV, 3'h5, 6'o12}, w, 1);
      ea = n * 50 - (ca >= cb ? 47 : 48);
      ca = p[47:0];
      p = ca * cb;
      w.d = ca[47] && !p[95] ? fpack(n[0], ea - n * 20 - 1, {p[46:0], 1'b0}) : fpack(n[0], ea - n * 20, p[47:0]);
      w.i = 3'h6;
      run({OP_DMUL, 3'h6, 6'o52}, w, 1);
    end
    a = fpack(0, 5, 48'h8000_0000_0000);
    b = fpack(0, 2, 48'h1000);
    run({OP_DIV, 3'h5, 6'o12}, note_t'{INDEF_WORD, 3'h5, 5'b00100, 1'b1}, 1);
    a = fpack(0, 1000, 48'h8000_0000_0000);
    b = fpack(0, -1000, 48'h1000);
    run({OP_DIV, 3'h6, 6'o12}, note_t'{INF_WORD, 3'h6, 5'b00100, 1'b1}, 1);
    @(negedge ref_clk);
    instr = {OP_MASK, 3'h3, 6'o77};
    issue_valid = 1'b1;
    repeat (5) @(negedge ref_clk);
    issue_valid = 1'b0;
    $display("divide test done");
    for (int k = 0; k < 8; k++) begin
      while (ready !== 1'b1) @(negedge ref_clk);
      psd_variant = k[2];
      a = {k[1] ? (k[0] ? IND_NEG : IND_POS) : (k[0] ? INF_NEG : INF_POS), 48'h0};
      b = fpack(0, 1, 48'h8000_0000_0000);
      w = note_t'{60'h0, 3'h7, k[1] ? (k[2] ? 5'b00001 : 5'b01000) : (k[2] ? 5'b00010 : 5'b10000), 1'b0};
      run({k[0] ? OP_DIV : OP_RMUL, 3'h7, 6'o12}, w, 1);
    end
    run({6'h25, 3'h7, 6'o12}, w, 0);
    repeat (60) @(negedge ref_clk);
    $display("condition and refusal test done");
    check_count++;
    if (q.size() != 0 || reads != want_reads) miss("pending result or read count off");
    final_report();
  end

  initial begin
    #100000;
    miss("timeout");
    final_report();
  end
endmodule
